// File: bas_pkg.sv
package bas_pkg;

  // Register offsets on the plain register port, in bytes.
  localparam logic [7:0] BAS_OFS_SETUP = 8'h00;
  localparam logic [7:0] BAS_OFS_WINDOW = 8'h04;

  // Width of the register data path.
  localparam int BAS_DW = 32;

  // The lowest base-address bit stands for this address bit.
  localparam int BAS_BASE_LSB = 4;
  // Number of base-address bits held in the window register.
  localparam int BAS_BASE_W = BAS_DW - BAS_BASE_LSB;
  // Size values below this disable the window.
  localparam logic [5:0] BAS_SIZE_MIN = 6'h04;

  // Field positions inside the setup register.
  localparam int BAS_SPACE_POS = 0;
  localparam int BAS_TYPE_LO = 1;
  localparam int BAS_TYPE_HI = 2;
  localparam int BAS_PREF_POS = 3;
  localparam int BAS_SIZE_LO = 4;
  localparam int BAS_SIZE_HI = 9;
  localparam int BAS_MODE_POS = 10;
  localparam int BAS_XLAT_LO = 11;
  localparam int BAS_XLAT_HI = 12;
  localparam int BAS_PART_LO = 13;
  localparam int BAS_PART_HI = 15;
  localparam int BAS_RSVD_LO = 16;
  localparam int BAS_RSVD_HI = 30;
  localparam int BAS_EN_POS = 31;

  // Fixed encodings of the read-only fields and of the first window's type.
  localparam logic bas_mode_window = 1'b0;
  localparam logic [1:0] BAS_XLAT_DIRECT = 2'h0;
  localparam logic [1:0] BAS_TYPE_ADDR64 = 2'h2;
  localparam logic BAS_SPACE_MEMORY = 1'b0;

  // Reset values.
  localparam logic [BAS_DW-1:0] BAS_WORD_RST = 32'h0000_0000;
  localparam logic [14:0] BAS_RSVD_VAL = 15'h0000;

  // Writable contents of the setup register.
  typedef struct packed {
    logic enable;
    logic [2:0] target_partition;
    logic [5:0] size;
    logic prefetch;
    logic [1:0] addr_type;
    logic space_indicator;
  } bas_setup_t;

  localparam bas_setup_t BAS_SETUP_RST = '{default: '0};

  // Decoded view of the window handed to the translation logic.
  typedef struct packed {
    logic active;
    logic paired;
    logic [5:0] size;
    logic [2:0] target_partition;
  } bas_view_t;

endpackage : bas_pkg

// File: bas_size_mask.sv
`timescale 1ns/1ps

// Turns the programmed size into a per-bit write and read mask for the
// base-address bits. Purely combinational so the main block can apply it
// on the very cycle of a write.
module bas_size_mask
  import bas_pkg::*;
#(
  parameter int BASE_W = BAS_BASE_W
) (
  input wire logic [5:0] size,
  output logic [BASE_W-1:0] mask
);

  // A size below the minimum turns every base bit into a read-only zero.
  logic size_valid;

  assign size_valid = (size >= BAS_SIZE_MIN);

  // One comparator per base bit; bit i stands for address bit i plus four.
  for (genvar i = 0; i < BASE_W; i++) begin : g_bit
    // Address position of this base bit, held one bit wider than the size field.
    localparam logic [6:0] ADDR_POS = 7'(i + BAS_BASE_LSB);
    // Writable only at or above the size value; sizes past 31 leave no bit
    // writable, so address bits beyond 32 are simply never stored.
    assign mask[i] = size_valid && (ADDR_POS >= {1'b0, size});
  end

endmodule : bas_size_mask

// File: bas_window_regs.sv
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Function
// - Six-bit size gives window as two-power.
// - Lowest base bit stands for address four.
// - Base bits at or above size writable.
// - Base bits below size read zero, unwritable.
// - Size below four disables the window.
// - Sizes above 31 ignore address bits past 32.
// - Paired with 64-bit first window: upper base.
// - Mode field reads constant zero, window mode.
// - Translation type reads constant zero, direct.
// - Writable three-bit target partition, resets zero.
// - Enable clear: window reads zero, ignored.
// - Memory-space first window of type two means 64-bit pairing.
module bas_window_regs
  import bas_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [BAS_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic first_space_indicator,
  input wire logic [1:0] first_addr_type,
  output logic [BAS_DW-1:0] reg_rdata_ff,
  output logic [BAS_DW-1:0] window_base_ff,
  output logic [BAS_DW-1:0] upper_base_ff,
  output bas_view_t window_view_ff
);

  // Stored writable fields of the setup register.
  bas_setup_t setup_ff;
  // Stored contents of the window register; unpaired, only masked bits are meaningful.
  logic [BAS_DW-1:0] window_ff;

  // Address decode of the two registers.
  logic hit_setup;
  logic hit_window;

  // Pairing condition taken from the first window's setup.
  logic paired;
  // Per-bit mask built from the programmed size.
  logic [BAS_BASE_W-1:0] base_mask;
  // Next value of the setup fields and of the window word.
  bas_setup_t nxt_setup;
  logic [BAS_DW-1:0] nxt_window;
  // Read views of the two registers.
  logic [BAS_DW-1:0] setup_word;
  logic [BAS_DW-1:0] window_word;
  logic [BAS_DW-1:0] nxt_rdata;
  // Derived values for the translation side.
  logic [BAS_DW-1:0] nxt_base;
  bas_view_t nxt_view;

  // The addresses are full-width compares; anything else is unmapped.
  assign hit_setup = (reg_addr == AW'(BAS_OFS_SETUP));
  assign hit_window = (reg_addr == AW'(BAS_OFS_WINDOW));

  // A memory-space first window with the 64-bit type takes this register
  // over as its upper half.
  assign paired = (first_space_indicator == BAS_SPACE_MEMORY) &&
                  (first_addr_type == BAS_TYPE_ADDR64);

  // The size mask is shared by the write path and the read path.
  bas_size_mask #(
    .BASE_W(BAS_BASE_W)
  ) u_mask (
    .size(setup_ff.size),
    .mask(base_mask)
  );

  // Setup write: every writable field stores, including the size while
  // paired, where it is kept but has no effect on decoding.
  always_comb begin
    nxt_setup = setup_ff;
    if (reg_wr && hit_setup) begin
      nxt_setup.space_indicator = reg_wdata[BAS_SPACE_POS];
      nxt_setup.addr_type = reg_wdata[BAS_TYPE_HI:BAS_TYPE_LO];
      nxt_setup.prefetch = reg_wdata[BAS_PREF_POS];
      nxt_setup.size = reg_wdata[BAS_SIZE_HI:BAS_SIZE_LO];
      nxt_setup.target_partition = reg_wdata[BAS_PART_HI:BAS_PART_LO];
      nxt_setup.enable = reg_wdata[BAS_EN_POS];
    end
  end

  // Setup register storage.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setup_ff <= BAS_SETUP_RST;
    end else begin
      setup_ff <= nxt_setup;
    end
  end

  // Window write. Paired, all 32 bits are plain upper base storage. Alone and
  // enabled, only base bits the mask allows take the new value; the rest keep
  // whatever they held, and the read path hides them only while the mask does,
  // so a later size change can expose stale bits.
  always_comb begin
    nxt_window = window_ff;
    if (reg_wr && hit_window) begin
      if (paired) begin
        nxt_window = reg_wdata;
      end else if (setup_ff.enable) begin
        for (int i = 0; i < BAS_BASE_W; i++) begin
          if (base_mask[i]) begin
            nxt_window[i + BAS_BASE_LSB] = reg_wdata[i + BAS_BASE_LSB];
          end
        end
      end
    end
  end

  // Window register storage.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      window_ff <= BAS_WORD_RST;
    end else begin
      window_ff <= nxt_window;
    end
  end

  // Setup read view: mode and translation type are constants, the
  // reserved span reads zero.
  always_comb begin
    setup_word = BAS_WORD_RST;
    setup_word[BAS_SPACE_POS] = setup_ff.space_indicator;
    setup_word[BAS_TYPE_HI:BAS_TYPE_LO] = setup_ff.addr_type;
    setup_word[BAS_PREF_POS] = setup_ff.prefetch;
    setup_word[BAS_SIZE_HI:BAS_SIZE_LO] = setup_ff.size;
    setup_word[BAS_MODE_POS] = bas_mode_window;
    setup_word[BAS_XLAT_HI:BAS_XLAT_LO] = BAS_XLAT_DIRECT;
    setup_word[BAS_PART_HI:BAS_PART_LO] = setup_ff.target_partition;
    setup_word[BAS_RSVD_HI:BAS_RSVD_LO] = BAS_RSVD_VAL;
    setup_word[BAS_EN_POS] = setup_ff.enable;
  end

  // Window read view. Paired, the whole word is the upper base. Disabled,
  // every field reads zero. Otherwise the base bits pass the size mask and
  // the low nibble reports the attributes chosen in setup.
  always_comb begin
    window_word = BAS_WORD_RST;
    if (paired) begin
      window_word = window_ff;
    end else if (setup_ff.enable) begin
      window_word[BAS_DW-1:BAS_BASE_LSB] = window_ff[BAS_DW-1:BAS_BASE_LSB] & base_mask;
      window_word[BAS_SPACE_POS] = setup_ff.space_indicator;
      window_word[BAS_TYPE_HI:BAS_TYPE_LO] = setup_ff.addr_type;
      window_word[BAS_PREF_POS] = setup_ff.prefetch;
    end else begin
      window_word = BAS_WORD_RST;
    end
  end

  // Read mux; an unmapped address reads zero and no read leaves zero too.
  always_comb begin
    nxt_rdata = BAS_WORD_RST;
    if (reg_rd) begin
      if (hit_setup) begin
        nxt_rdata = setup_word;
      end else if (hit_window) begin
        nxt_rdata = window_word;
      end else begin
        nxt_rdata = BAS_WORD_RST;
      end
    end
  end

  // Read data stands in the cycle after the strobe and only there.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= BAS_WORD_RST;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // Decoded view for the translation datapath. The window counts as active
  // only when enabled, not paired and with a size that enables decoding.
  always_comb begin
    nxt_view.paired = paired;
    nxt_view.active = setup_ff.enable && !paired && (setup_ff.size >= BAS_SIZE_MIN);
    nxt_view.size = paired ? 6'h00 : setup_ff.size;
    nxt_view.target_partition = nxt_view.active ? setup_ff.target_partition : 3'h0;
  end

  // Effective base address with the size mask applied and low bits zero.
  always_comb begin
    nxt_base = BAS_WORD_RST;
    if (nxt_view.active) begin
      nxt_base[BAS_DW-1:BAS_BASE_LSB] = window_ff[BAS_DW-1:BAS_BASE_LSB] & base_mask;
    end
  end

  // Registered outputs toward the translation logic. They trail the
  // registers by one cycle, which the datapath tolerates because setup
  // changes while traffic flows are not supported.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      window_view_ff <= '{default: '0};
      window_base_ff <= BAS_WORD_RST;
      upper_base_ff <= BAS_WORD_RST;
    end else begin
      window_view_ff <= nxt_view;
      window_base_ff <= nxt_base;
      upper_base_ff <= paired ? window_ff : BAS_WORD_RST;
    end
  end

endmodule : bas_window_regs

// File: bas_monitor.sv
`timescale 1ns/1ps

// Watches the register port and the decoded window outputs of the block.
module bas_monitor
  import bas_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [BAS_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic first_space_indicator,
  input wire logic [1:0] first_addr_type,
  input wire logic [BAS_DW-1:0] reg_rdata_ff,
  input wire logic [BAS_DW-1:0] window_base_ff,
  input wire logic [BAS_DW-1:0] upper_base_ff,
  input wire bas_view_t window_view_ff
);
  logic [31:0] allowed; // Base bits that the shown size lets through.
  logic pair_req; // The first window asks for 64-bit pairing.
  logic en_ff; // Last enable written to the setup register.
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  assign pair_req = !first_space_indicator && first_addr_type == BAS_TYPE_ADDR64;
  // Legal base bits follow the view's size, so a lagging mask shows up here.
  always_comb begin
    allowed = '0;
    for (int i = 4; i < 32; i++) allowed[i] = window_view_ff.size >= BAS_SIZE_MIN && i >= window_view_ff.size;
  end
  // Tracks the enable so disabled reads can be judged without a full model.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) en_ff <= 1'b0;
    else if (reg_wr && reg_addr == BAS_OFS_SETUP) en_ff <= reg_wdata[31];
  end
  // A setup write that enables the window with a size that opens decoding.
  sequence setup_wr_s;
    reg_wr && reg_addr == BAS_OFS_SETUP && reg_wdata[31] && reg_wdata[9:4] >= BAS_SIZE_MIN;
  endsequence
  sequence pair_held_s;
    pair_req [*3];
  endsequence
  sequence single_held_s;
    !pair_req [*3];
  endsequence
  mode_zero_a: assert property (reg_rd && reg_addr == BAS_OFS_SETUP |=> reg_rdata_ff[10] == 1'b0)
    else $error("mode bit read back non-zero");
  xlat_zero_a: assert property (reg_rd && reg_addr == BAS_OFS_SETUP |=>
    reg_rdata_ff[12:11] == BAS_XLAT_DIRECT && reg_rdata_ff[30:16] == '0) else $error("read-only bits not zero");
  base_nibble_a: assert property (window_base_ff[3:0] == 4'h0) else $error("base below bit four set");
  base_mask_a: assert property ((window_base_ff & ~allowed) == '0) else $error("base bit below size set");
  small_off_a: assert property (window_view_ff.size < BAS_SIZE_MIN |-> window_base_ff == '0)
    else $error("small size left window open");
  wide_off_a: assert property (window_view_ff.size > 6'h1f |-> window_base_ff == '0) else $error("wide size kept bits");
  part_track_a: assert property (setup_wr_s ##1 (!(reg_wr && reg_addr == BAS_OFS_SETUP) && !pair_req) |=>
    window_view_ff.target_partition ==
    $past(reg_wdata[15:13], 2) && window_view_ff.size == $past(reg_wdata[9:4], 2)) else $error("view lost setup");
  pair_on_a: assert property (pair_held_s |-> window_view_ff.paired) else $error("pairing not shown");
  pair_off_a: assert property (single_held_s |-> !window_view_ff.paired && upper_base_ff == '0)
    else $error("pairing shown without request");
  en_off_a: assert property (reg_rd && reg_addr == BAS_OFS_WINDOW && !en_ff && !pair_req |=> reg_rdata_ff == '0)
    else $error("disabled window read non-zero");
endmodule : bas_monitor

bind bas_window_regs bas_monitor #(.AW(AW)) bas_monitor_i (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .first_space_indicator, .first_addr_type, .reg_rdata_ff, .window_base_ff, .upper_base_ff, .window_view_ff);

// File: tb_top.sv
`timescale 1ns/1ps

// Drives the register port at random and compares reads with a small model.
module tb_top;
  import bas_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic first_space_indicator = 1'b0;
  logic [1:0] first_addr_type = 2'h0;
  logic [31:0] reg_rdata_ff, window_base_ff, upper_base_ff;
  bas_view_t window_view_ff;
  logic [31:0] m_setup = 32'h0; // Model of the setup register.
  logic [31:0] m_word = 32'h0; // Model of the stored window word.
  logic [31:0] seed = 32'd32755; // Fixed seed keeps runs repeatable.
  logic [31:0] r, d;
  logic [5:0] sizes [7] = '{6'h00, 6'h03, 6'h04, 6'h07, 6'h1f, 6'h20, 6'h3f};
  int failures = 0;
  int comparisons = 0;
  always #20 clock = ~clock;
  bas_window_regs bas_window_regs_i (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .first_space_indicator,
    .first_addr_type, .reg_rdata_ff, .window_base_ff, .upper_base_ff, .window_view_ff);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Base bits that a size lets software write.
  function automatic logic [31:0] size_mask(input logic [5:0] s);
    size_mask = '0;
    for (int i = 4; i < 32; i++) size_mask[i] = s >= 6'h04 && i >= s;
  endfunction : size_mask
  function automatic logic [31:0] exp_read(input logic [7:0] a, input logic pr);
    if (a == BAS_OFS_SETUP) return m_setup;
    if (a != BAS_OFS_WINDOW) return 32'h0;
    if (pr) return m_word;
    if (!m_setup[31]) return 32'h0;
    return (m_word & size_mask(m_setup[9:4])) | {28'h0, m_setup[3:0]};
  endfunction : exp_read
  // Decoded outputs trail the registers by one cycle, so they are judged a cycle after the access.
  // Read data must have gone back to zero by then, since no read was made in between.
  task automatic check_out(input logic pr);
    bas_view_t ev;
    logic [31:0] eb;
    logic [31:0] eu;
    ev.active = m_setup[31] && !pr && m_setup[9:4] >= 6'h04;
    ev.paired = pr;
    ev.size = pr ? 6'h00 : m_setup[9:4];
    ev.target_partition = ev.active ? m_setup[15:13] : 3'h0;
    eb = ev.active ? (m_word & size_mask(m_setup[9:4])) : 32'h0;
    eu = pr ? m_word : 32'h0;
    comparisons++;
    if ({window_view_ff, window_base_ff, upper_base_ff, reg_rdata_ff} !== {ev, eb, eu, 32'h0}) begin
      failures++;
      $display("[FAIL] window outputs expected %h %h %h 0 seen %h %h %h %h", ev, eb, eu, window_view_ff,
        window_base_ff, upper_base_ff, reg_rdata_ff);
    end
  endtask : check_out
  // One write or read; read data is checked in the single cycle it stands, and a write must leave it zero.
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [2:0] fp);
    logic pr;
    logic [31:0] exp;
    pr = !fp[2] && fp[1:0] == BAS_TYPE_ADDR64;
    exp = w ? 32'h0 : exp_read(a, pr);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= w;
    reg_rd <= !w;
    {first_space_indicator, first_addr_type} <= fp;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    if (w && a == BAS_OFS_SETUP) m_setup = dat & 32'h8000_e3ff;
    if (w && a == BAS_OFS_WINDOW && pr) m_word = dat;
    else if (w && a == BAS_OFS_WINDOW && m_setup[31]) m_word = (m_word & ~size_mask(m_setup[9:4])) | (dat & size_mask(m_setup[9:4]));
    #1;
    comparisons++;
    if (reg_rdata_ff !== exp) begin
      failures++;
      $display("[FAIL] reg_rdata_ff at %h expected %h seen %h", a, exp, reg_rdata_ff);
    end
    @(posedge clock);
    #1;
    check_out(pr);
  endtask : access
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    access(1'b0, 8'h00, 32'h0, 3'h4);
    access(1'b1, 8'h00, 32'hffff_ffff, 3'h4);
    access(1'b0, 8'h00, 32'h0, 3'h4);
    access(1'b1, 8'h00, 32'h0000_0070, 3'h4);
    access(1'b1, 8'h04, 32'h1234_5670, 3'h4);
    access(1'b0, 8'h04, 32'h0, 3'h4);
    foreach (sizes[k]) begin
      access(1'b1, 8'h00, 32'h8000_a00d | {22'h0, sizes[k], 4'h0}, 3'h4);
      access(1'b1, 8'h04, 32'hffff_ffff, 3'h4);
      access(1'b0, 8'h04, 32'h0, 3'h4);
      access(1'b0, 8'h00, 32'h0, 3'h4);
    end
    access(1'b1, 8'h04, 32'hdead_beef, 3'h2);
    access(1'b0, 8'h04, 32'h0, 3'h2);
    access(1'b0, 8'h04, 32'h0, 3'h0);
    for (int n = 0; n < 400; n++) begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      d = seed;
      if (r[3:2] == 2'h0) d[9:4] = 6'h07 + 6'(r[24:20] % 5'd25);
      access(r[4], {4'h0, r[3:2], 2'h0}, d, r[7:5]);
    end
    end_sim();
  end
endmodule : tb_top
